// ===== src/ramp_spread_map.vh
// register map and field positions of the ramp phase and spread control block
// assumes byte-wide registers reached over a two-wire serial control bus
`ifndef RAMP_SPREAD_MAP_VH
`define RAMP_SPREAD_MAP_VH

`define OFS_AUTO_MUTE_STATUS   8'h69
`define OFS_RAMP_PHASE_CONTROL 8'h6A
`define OFS_SPREAD_CONTROL_0   8'h6B
`define OFS_SPREAD_CONTROL_1   8'h6C

`define RST_AUTO_MUTE_STATUS   2'h0
`define RST_RAMP_PHASE_SEL     2'h0
`define RST_BIT                1'b0
`define RST_RANDOM_RANGE       3'h0
`define RST_TRI_CTRL           4'h0

`define BIT_LEFT_MUTED         0
`define BIT_RIGHT_MUTED        1
`define BIT_PHASE_SYNC_EN      0
`define BIT_I2S_ALIGN_EN       1
`define FLD_PHASE_SEL_LO       2
`define FLD_PHASE_SEL_HI       3
`define BIT_TRI_EN             0
`define BIT_RANDOM_EN          1
`define BIT_MANUAL_MODE        4
`define BIT_PRE_DIV_SEL        5
`define FLD_TRI_LO             0
`define FLD_TRI_HI             3
`define FLD_RANDOM_LO          4
`define FLD_RANDOM_HI          6

`define LAST_BIT_IDX           3'h7
`define DEV_ADDR_DEFAULT       7'h2C

`endif

// ===== src/pwm_ramp_phase_spread_ctrl.v
// ramp clock phase, phase sync and spread spectrum control registers with serial slave
// assumes scl/sda and the frame clock arrive from pins; mute flags come from local logic
`timescale 1ns/1ps
`default_nettype none
`include "ramp_spread_map.vh"

// Functional notes
// R1: status bit 1 reads 1 while the right channel is auto-muted and 0 otherwise.
// R2: status bit 0 reads 1 while the left channel is auto-muted and 0 otherwise.
// R3: phase control bits 3-2 select one of four ramp clock phases, 00 phase 0 to 11 phase 3.
// R4: the host sets the ramp phase before sending the device into play when staggering is used.
// R5: the host should give all staggered devices the same ramp frequency and spread settings.
// R6: phase control bit 1 set aligns output PWM phase to the serial audio frame, clear does not.
// R7: phase control bit 0 enables ramp phase synchronisation when 1 and disables it when 0.
// R8: spread control 0 bit 5 in manual mode selects the PLL clock divided by two as source.
// R9: spread control 0 bit 4 set puts the spread controller in manual mode, clear is automatic.
// R10: spread control 0 bit 1 enables random spread, whose range is spread control 1 bits 6-4.
// R11: spread control 0 bit 0 enables triangle spread, set by spread control 1 bits 3-0.
// R12: the auto-mute status register sits at offset 69h and resets to zero.
// R13: reserved bits read as zero and writes to them have no effect.
module pwm_ramp_phase_spread_ctrl #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    input  wire       clk_sys_i,
    input  wire       sys_rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    input  wire       frame_clk_i,
    input  wire       left_muted_i,
    input  wire       right_muted_i,
    output wire [1:0] ramp_phase_sel_o,
    output wire       phase_sync_en_o,
    output wire       i2s_align_en_o,
    output wire       pwm_realign_o,
    output wire       spread_manual_o,
    output wire       spread_pre_div_o,
    output wire       spread_clk_en_o,
    output wire       tri_spread_enable_o,
    output wire       random_spread_enable_o,
    output wire [3:0] tri_spread_ctrl_o,
    output wire [2:0] random_spread_range_o
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_ACK   = 3'h2;
    localparam [2:0] ST_ACKH  = 3'h3;
    localparam [2:0] ST_WRITE = 3'h4;
    localparam [2:0] ST_READ  = 3'h5;
    localparam [2:0] ST_RACK  = 3'h6;
    localparam [2:0] ST_RNEXT = 3'h7;

    reg  [2:0] scl_sync_q;
    reg  [2:0] sda_sync_q;
    reg  [2:0] frm_sync_q;
    reg  [2:0] state_q;
    reg  [2:0] bit_cnt_q;
    reg  [7:0] shift_q;
    reg  [7:0] ptr_q;
    reg        ptr_phase_q;
    reg        rw_q;
    reg        sda_oe_q;

    reg  [1:0] mute_q;
    reg  [1:0] phase_sel_q;
    reg        phase_sync_q;
    reg        align_q;
    reg        realign_q;
    reg        manual_q;
    reg        pre_div_q;
    reg        tri_en_q;
    reg        rdm_en_q;
    reg  [3:0] tri_ctrl_q;
    reg  [2:0] rdm_range_q;
    reg        div_q;
    reg        clk_en_q;

    wire       scl_s    = scl_sync_q[1];
    wire       scl_p    = scl_sync_q[2];
    wire       sda_s    = sda_sync_q[1];
    wire       sda_p    = sda_sync_q[2];
    wire       scl_rise = scl_s & ~scl_p;
    wire       scl_fall = ~scl_s & scl_p;
    wire       bus_start = scl_s & scl_p & sda_p & ~sda_s;
    wire       bus_stop  = scl_s & scl_p & ~sda_p & sda_s;
    wire [7:0] in_byte  = {shift_q[6:0], sda_s};
    wire       last_bit = (bit_cnt_q == `LAST_BIT_IDX);
    wire       wr_en    = (state_q == ST_WRITE) & scl_rise & last_bit & ~ptr_phase_q;

    // read mux; unmapped offsets and reserved bits read zero
    function [7:0] reg_read;
        input [7:0] addr;
        begin
            reg_read = 8'h00;
            case (addr)
                `OFS_AUTO_MUTE_STATUS: begin
                    reg_read[`BIT_LEFT_MUTED]  = mute_q[0]; // R2
                    reg_read[`BIT_RIGHT_MUTED] = mute_q[1]; // R1
                end
                `OFS_RAMP_PHASE_CONTROL: begin
                    reg_read[`FLD_PHASE_SEL_HI:`FLD_PHASE_SEL_LO] = phase_sel_q;
                    reg_read[`BIT_I2S_ALIGN_EN]  = align_q;
                    reg_read[`BIT_PHASE_SYNC_EN] = phase_sync_q;
                end
                `OFS_SPREAD_CONTROL_0: begin
                    reg_read[`BIT_PRE_DIV_SEL] = pre_div_q;
                    reg_read[`BIT_MANUAL_MODE] = manual_q;
                    reg_read[`BIT_RANDOM_EN]   = rdm_en_q;
                    reg_read[`BIT_TRI_EN]      = tri_en_q;
                end
                `OFS_SPREAD_CONTROL_1: begin
                    reg_read[`FLD_RANDOM_HI:`FLD_RANDOM_LO] = rdm_range_q;
                    reg_read[`FLD_TRI_HI:`FLD_TRI_LO]       = tri_ctrl_q;
                end
                default: begin
                    reg_read = 8'h00; // R13
                end
            endcase
        end
    endfunction

    wire [7:0] rd_byte = reg_read(ptr_q);

    // pin synchronisers
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            frm_sync_q <= 3'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            frm_sync_q <= {frm_sync_q[1:0], frame_clk_i};
        end
    end

    // serial slave: shift in on scl rise, drive sda after scl fall
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 3'h0;
            shift_q     <= 8'h00;
            ptr_q       <= 8'h00;
            ptr_phase_q <= 1'b0;
            rw_q        <= 1'b0;
            sda_oe_q    <= 1'b0;
        end else if (bus_start) begin
            state_q     <= ST_ADDR;
            bit_cnt_q   <= 3'h0;
            ptr_phase_q <= 1'b1;
            sda_oe_q    <= 1'b0;
        end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q   <= in_byte;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (last_bit) begin
                            rw_q    <= in_byte[0];
                            state_q <= (in_byte[7:1] == DEV_ADDR) ? ST_ACK : ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b1;
                        state_q  <= ST_ACKH;
                    end
                end
                ST_ACKH: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        if (rw_q) begin
                            shift_q  <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            ptr_q    <= ptr_q + 8'h01;
                            state_q  <= ST_READ;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        shift_q   <= in_byte;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (last_bit) begin
                            state_q     <= ST_ACK;
                            ptr_phase_q <= 1'b0;
                            if (ptr_phase_q) begin
                                ptr_q <= in_byte;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (last_bit) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_RACK;
                        end else begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= ~shift_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state_q <= sda_s ? ST_IDLE : ST_RNEXT;
                    end
                end
                ST_RNEXT: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        shift_q   <= rd_byte;
                        sda_oe_q  <= ~rd_byte[7];
                        ptr_q     <= ptr_q + 8'h01;
                        state_q   <= ST_READ;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // control registers; only defined bits are stored
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            phase_sel_q  <= `RST_RAMP_PHASE_SEL;
            phase_sync_q <= `RST_BIT;
            align_q      <= `RST_BIT;
            manual_q     <= `RST_BIT;
            pre_div_q    <= `RST_BIT;
            tri_en_q     <= `RST_BIT;
            rdm_en_q     <= `RST_BIT;
            tri_ctrl_q   <= `RST_TRI_CTRL;
            rdm_range_q  <= `RST_RANDOM_RANGE;
        end else if (wr_en) begin
            case (ptr_q)
                `OFS_RAMP_PHASE_CONTROL: begin
                    phase_sel_q  <= in_byte[`FLD_PHASE_SEL_HI:`FLD_PHASE_SEL_LO]; // R3
                    align_q      <= in_byte[`BIT_I2S_ALIGN_EN]; // R6
                    phase_sync_q <= in_byte[`BIT_PHASE_SYNC_EN]; // R7
                end
                `OFS_SPREAD_CONTROL_0: begin
                    pre_div_q <= in_byte[`BIT_PRE_DIV_SEL]; // R8
                    manual_q  <= in_byte[`BIT_MANUAL_MODE]; // R9
                    rdm_en_q  <= in_byte[`BIT_RANDOM_EN]; // R10
                    tri_en_q  <= in_byte[`BIT_TRI_EN]; // R11
                end
                `OFS_SPREAD_CONTROL_1: begin
                    rdm_range_q <= in_byte[`FLD_RANDOM_HI:`FLD_RANDOM_LO]; // R10
                    tri_ctrl_q  <= in_byte[`FLD_TRI_HI:`FLD_TRI_LO]; // R11
                end
                default: begin
                    phase_sel_q <= phase_sel_q; // R13
                end
            endcase
        end
    end

    // status capture, frame alignment and spread source clock enable
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mute_q    <= `RST_AUTO_MUTE_STATUS; // R12
            realign_q <= 1'b0;
            div_q     <= 1'b0;
            clk_en_q  <= 1'b0;
        end else begin
            mute_q    <= {right_muted_i, left_muted_i}; // R1
            realign_q <= align_q & frm_sync_q[1] & ~frm_sync_q[2]; // R6
            div_q     <= ~div_q;
            clk_en_q  <= (manual_q & pre_div_q) ? div_q : 1'b1; // R8
        end
    end

    assign sda_o                  = 1'b0;
    assign sda_oe_o               = sda_oe_q;
    assign ramp_phase_sel_o       = phase_sel_q;
    assign phase_sync_en_o        = phase_sync_q;
    assign i2s_align_en_o         = align_q;
    assign pwm_realign_o          = realign_q;
    assign spread_manual_o        = manual_q;
    assign spread_pre_div_o       = pre_div_q;
    assign spread_clk_en_o        = clk_en_q;
    assign tri_spread_enable_o    = tri_en_q;
    assign random_spread_enable_o = rdm_en_q;
    assign tri_spread_ctrl_o      = tri_ctrl_q;
    assign random_spread_range_o  = rdm_range_q;

endmodule
`default_nettype wire

// ===== test/host_bus_model.sv
// host controller model: master on the two-wire register port
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module host_bus_model #(
    parameter logic [6:0] ADDR = 7'h2C
) (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic pull_o
);
    logic s;
    int   nacks = 0;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // one bus phase of 7 cycles, driven at a rising edge
    task automatic line(input logic c, input logic d);
        @(posedge clk_sys_i);
        scl_o <= c;
        pull_o <= ~d;
        repeat (7) @(negedge clk_sys_i);
    endtask
    // data changes only while the clock is low
    task automatic bitx(input logic b, output logic r);
        line(1'b0, b);
        line(1'b1, b);
        r = sda_i;
        line(1'b0, b);
    endtask
    task automatic start();
        line(1'b0, 1'b1);
        line(1'b1, 1'b1);
        line(1'b1, 1'b0);
        line(1'b0, 1'b0);
    endtask
    task automatic stop();
        line(1'b0, 1'b0);
        line(1'b1, 1'b0);
        line(1'b1, 1'b1);
    endtask
    task automatic tx(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        if (s !== 1'b0) nacks++;
    endtask
    // one byte from the device, then the master's acknowledge or not
    task automatic rxb(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, s);
    endtask
    // registers are all set before playback; one device shares no settings
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        tx({ADDR, 1'b0});
        tx(a);
        tx(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        start();
        tx({ADDR, 1'b0});
        tx(a);
        start();
        tx({ADDR, 1'b1});
        rxb(1'b1, d);
        stop();
    endtask
    // two bytes in one read, the pointer stepping between them
    task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        start();
        tx({ADDR, 1'b0});
        tx(a);
        start();
        tx({ADDR, 1'b1});
        rxb(1'b0, d0);
        rxb(1'b1, d1);
        stop();
    endtask
    // write to a foreign address; every byte goes unacknowledged
    task automatic badwr(input logic [7:0] a, input logic [7:0] d);
        start();
        tx({ADDR ^ 7'h01, 1'b0});
        tx(a);
        tx(d);
        stop();
    endtask
endmodule
`default_nettype wire

// ===== test/ramp_spread_asserts.sv
// concurrent checks on the ramp phase and spread control ports
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ramp_spread_asserts (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       scl_i,
    input wire logic       frame_clk_i,
    input wire logic       sda_oe_o,
    input wire logic [1:0] ramp_phase_sel_o,
    input wire logic       phase_sync_en_o,
    input wire logic       i2s_align_en_o,
    input wire logic       pwm_realign_o,
    input wire logic       spread_manual_o,
    input wire logic       spread_pre_div_o,
    input wire logic       spread_clk_en_o,
    input wire logic [3:0] tri_spread_ctrl_o,
    input wire logic [2:0] random_spread_range_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire        both = spread_manual_o & spread_pre_div_o;
    logic [1:0] since_rst;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) since_rst <= 2'h0;
        else if (since_rst != 2'h3) since_rst <= since_rst + 2'h1;
    end
    a_realign_rise: assert property (
        $rose(frame_clk_i) && i2s_align_en_o |-> ##[2:5] pwm_realign_o)
        else $error("no realign pulse after frame start");
    a_realign_origin: assert property (
        pwm_realign_o |-> $past(frame_clk_i, 2) && !$past(frame_clk_i, 8))
        else $error("realign pulse without frame start");
    a_pulse_single: assert property (pwm_realign_o |=> !pwm_realign_o)
        else $error("realign pulse longer than one cycle");
    a_align_off: assert property (
        !i2s_align_en_o && !$past(i2s_align_en_o) |-> !pwm_realign_o)
        else $error("realign pulse while alignment off");
    a_sda_edge: assert property (!$stable(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while serial clock high");
    a_mirror_phase: assert property (
        !$stable({ramp_phase_sel_o, phase_sync_en_o, i2s_align_en_o}) |-> scl_i)
        else $error("phase outputs changed outside a write");
    a_mirror_spread: assert property (
        !$stable({spread_manual_o, tri_spread_ctrl_o, random_spread_range_o}) |-> scl_i)
        else $error("spread outputs changed outside a write");
    a_clk_alt: assert property (both [*4] |-> spread_clk_en_o != $past(spread_clk_en_o))
        else $error("halved spread clock not alternating");
    a_clk_full: assert property (
        since_rst == 2'h3 && !both && !$past(both) |-> spread_clk_en_o)
        else $error("spread clock enable low at full rate");
    c_realign: cover property (pwm_realign_o);
    c_halved: cover property (both ##1 !spread_clk_en_o);
    c_drive: cover property ($rose(sda_oe_o));
endmodule
`default_nettype wire

// ===== test/test_pwm_ramp_phase_spread_ctrl.sv
// self-checking bench for the ramp phase and spread control block
// assumes the host model reaches all registers over the serial pins
`timescale 1ns/1ps
`default_nettype none
module test_pwm_ramp_phase_spread_ctrl;
    logic       clk_sys_i, sys_rst_i, frame_clk_i, left_muted_i, right_muted_i, pull;
    logic [7:0] d, d2;
    int         fails, n_compared, pulses, p0, hi;
    logic [7:0] s0 [5] = '{8'hFF, 8'h10, 8'h20, 8'h01, 8'h02};
    logic [7:0] s1 [3] = '{8'hFF, 8'h5A, 8'hA5};
    wire logic       scl_i, sda_o, sda_oe_o, phase_sync_en_o, i2s_align_en_o, pwm_realign_o;
    wire logic       spread_manual_o, spread_pre_div_o, spread_clk_en_o;
    wire logic       tri_spread_enable_o, random_spread_enable_o;
    wire logic [1:0] ramp_phase_sel_o;
    wire logic [3:0] tri_spread_ctrl_o;
    wire logic [2:0] random_spread_range_o;
    wire logic       sda_i = !(pull || (sda_oe_o && !sda_o));
    pwm_ramp_phase_spread_ctrl DUT (
        .clk_sys_i              (clk_sys_i),
        .sys_rst_i              (sys_rst_i),
        .scl_i                  (scl_i),
        .sda_i                  (sda_i),
        .sda_o                  (sda_o),
        .sda_oe_o               (sda_oe_o),
        .frame_clk_i            (frame_clk_i),
        .left_muted_i           (left_muted_i),
        .right_muted_i          (right_muted_i),
        .ramp_phase_sel_o       (ramp_phase_sel_o),
        .phase_sync_en_o        (phase_sync_en_o),
        .i2s_align_en_o         (i2s_align_en_o),
        .pwm_realign_o          (pwm_realign_o),
        .spread_manual_o        (spread_manual_o),
        .spread_pre_div_o       (spread_pre_div_o),
        .spread_clk_en_o        (spread_clk_en_o),
        .tri_spread_enable_o    (tri_spread_enable_o),
        .random_spread_enable_o (random_spread_enable_o),
        .tri_spread_ctrl_o      (tri_spread_ctrl_o),
        .random_spread_range_o  (random_spread_range_o)
    );
    host_bus_model host (.clk_sys_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl_i), .pull_o(pull));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (pwm_realign_o === 1'b1) pulses <= pulses + 1;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk(d, e);
    endtask
    task automatic frames(input int n);
        repeat (2 * n) begin
            repeat (20) @(posedge clk_sys_i);
            frame_clk_i <= ~frame_clk_i;
        end
        repeat (8) @(negedge clk_sys_i);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_sys_i);
        fails++;
        conclude();
    end
    initial begin
        {sys_rst_i, frame_clk_i, left_muted_i, right_muted_i} = 4'h8;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        for (logic [7:0] a = 8'h69; a <= 8'h6D; a++) rchk(a, 8'h00);
        $display("reset values done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys_i);
            {right_muted_i, left_muted_i} <= m[1:0];
            host.wr(8'h69, 8'hFF);
            rchk(8'h69, {6'h00, m[1:0]});
        end
        $display("mute status done");
        for (int p = 0; p < 4; p++) begin
            host.wr(8'h6A, {4'hF, p[1:0], 2'h0});
            chk({6'h00, ramp_phase_sel_o}, {6'h00, p[1:0]});
            rchk(8'h6A, {4'h0, p[1:0], 2'h0});
            host.wr(8'h6A, {6'h00, p[1:0]});
            chk({6'h00, i2s_align_en_o, phase_sync_en_o}, {6'h00, p[1:0]});
            p0 = pulses;
            frames(2);
            chk(8'(pulses - p0), p[1] ? 8'h02 : 8'h00);
        end
        $display("phase control done");
        foreach (s0[i]) begin
            host.wr(8'h6B, s0[i]);
            rchk(8'h6B, s0[i] & 8'h33);
            chk({4'h0, spread_pre_div_o, spread_manual_o,
                 random_spread_enable_o, tri_spread_enable_o}, {4'h0, s0[i][5:4], s0[i][1:0]});
            hi = 0;
            repeat (8) begin
                @(negedge clk_sys_i);
                hi += (spread_clk_en_o === 1'b1);
            end
            chk(hi[7:0], (s0[i][5] && s0[i][4]) ? 8'h04 : 8'h08);
        end
        $display("spread control 0 done");
        foreach (s1[i]) begin
            host.wr(8'h6C, s1[i]);
            rchk(8'h6C, s1[i] & 8'h7F);
            chk({1'b0, random_spread_range_o, tri_spread_ctrl_o}, s1[i] & 8'h7F);
        end
        host.wr(8'h6D, 8'hFF);
        rchk(8'h6D, 8'h00);
        host.badwr(8'h6C, 8'hFF);
        rchk(8'h6C, 8'h25);
        host.rd2(8'h6B, d, d2);
        chk(d, 8'h02);
        chk(d2, 8'h25);
        chk(host.nacks[7:0], 8'h03);
        $display("spread control 1 done");
        conclude();
    end
endmodule
bind pwm_ramp_phase_spread_ctrl ramp_spread_asserts u_chk (.clk_sys_i, .sys_rst_i, .scl_i,
    .frame_clk_i, .sda_oe_o, .ramp_phase_sel_o, .phase_sync_en_o, .i2s_align_en_o,
    .pwm_realign_o, .spread_manual_o, .spread_pre_div_o, .spread_clk_en_o,
    .tri_spread_ctrl_o, .random_spread_range_o);
`default_nettype wire
